// File: codec_cfg_pkg.sv
package codec_cfg_pkg;

    // ---------------------------------------------------------------
    // Serial word and register map
    // ---------------------------------------------------------------
    localparam int unsigned WORD_BITS = 16;
    localparam int unsigned NUM_REGS = 8;
    localparam logic [7:0] ADDR_VOICEBAND_CODEC_SETUP = 8'h01;
    localparam logic [7:0] ADDR_MICROPHONE_PREAMP_SETUP = 8'h02;
    localparam logic [7:0] ADDR_HEADPHONE_LEVEL_SETUP = 8'h03;
    localparam logic [7:0] ADDR_LOUDSPEAKER_LEVEL_SETUP = 8'h04;
    localparam logic [7:0] ADDR_SYNTH_INPUT_DIVIDER = 8'h05;
    localparam logic [7:0] ADDR_SYNTH_FEEDBACK_DIVIDER = 8'h06;
    localparam logic [7:0] ADDR_SYNTH_OUTPUT_DIVIDER = 8'h07;
    localparam logic [7:0] ADDR_CLOCK_SOURCE_SELECT = 8'h08;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ---------------------------------------------------------------
    // Field positions
    // ---------------------------------------------------------------
    localparam int unsigned AUTO_SIDE_BIT = 4;
    localparam int unsigned VADC_SHAPING_BIT = 6;
    localparam int unsigned VDAC_SHAPING_BIT = 7;
    localparam int unsigned MIC_SILENCE_BIT = 4;
    localparam int unsigned HIGHPASS_BIT = 7;
    localparam int unsigned HP_SILENCE_BIT = 5;
    localparam int unsigned POLARITY_BIT = 6;
    localparam int unsigned INDICATION_BIT = 7;
    localparam int unsigned LS_SILENCE_BIT = 5;
    localparam int unsigned LS_JACK_BIT = 6;
    localparam int unsigned CLASS_D_BIT = 7;
    localparam int unsigned MOD_HIGH_LSB = 5;
    localparam int unsigned MOD_LOW_LSB = 4;
    localparam int unsigned OSC_RANGE_BIT = 7;
    localparam int unsigned DITHER_LSB = 6;
    localparam int unsigned CLK_SOURCE_BIT = 0;

    // ---------------------------------------------------------------
    // Decode constants
    // ---------------------------------------------------------------
    localparam logic [3:0] SIDETONE_TOP_CODE = 4'hb;
    localparam logic [4:0] IN_DIV_FIXUP_CODE = 5'h03;
    localparam logic [4:0] IN_DIV_MIN = 5'h04;
    localparam logic [4:0] IN_DIV_BYPASS = 5'h01;
    localparam logic [6:0] FB_DIV_MIN = 7'h04;
    localparam logic [3:0] OUT_DIV_MIN = 4'h4;
    localparam logic [5:0] DITHER_MAG_00 = 6'h20;
    localparam logic [5:0] DITHER_MAG_01 = 6'h10;
    localparam logic [5:0] DITHER_MAG_10 = 6'h30;
    localparam logic [5:0] DITHER_MAG_11 = 6'h00;

    // ---------------------------------------------------------------
    // Carriers
    // ---------------------------------------------------------------
    typedef struct packed {
        logic sclk;
        logic enable_n;
        logic data;
    } serial_pins_t;

    typedef struct packed {
        logic [3:0] sidetone_level;
        logic sidetone_on;
        logic voice_adc_noise_shaping_off;
        logic voice_dac_noise_shaping_off;
    } voice_ctrl_t;

    typedef struct packed {
        logic [3:0] mic_level;
        logic mic_silence;
        logic voice_highpass_bypass;
    } mic_ctrl_t;

    typedef struct packed {
        logic [4:0] headphone_level;
        logic headphone_silence;
        logic jack_present_indication;
    } headphone_ctrl_t;

    typedef struct packed {
        logic [4:0] loudspeaker_level;
        logic loudspeaker_silence;
        logic class_d_off;
        logic external_amp_enable;
    } loudspeaker_ctrl_t;

    typedef struct packed {
        logic [4:0] input_divide;
        logic [6:0] feedback_integer;
        logic [4:0] modulus;
        logic [11:0] feedback_ratio_x32;
        logic [3:0] output_divide;
        logic [8:0] total_divide;
        logic oscillator_high_range;
        logic [5:0] dither_magnitude;
        logic clock_source_select;
    } synth_ctrl_t;

endpackage : codec_cfg_pkg

// File: audio_codec_gain_pll_regs.sv
// ---------------------------------------------------------------
// Contract
// - Sidetone code 0 mutes, 1..11 step 3dB up to 0dB, above 11 is 0dB
// - Auto-side bit kills sidetone in speaker mode unless jack-silenced
// - Mic level code 0..15 gives 6dB to 36dB in 2dB steps
// - Mic silence bit mutes preamp and voice ADC output
// - Highpass bypass bit disables voice ADC highpass filter
// - Headphone code 0..31 spans -46.5dB to 0dB, 1.5dB steps
// - Headphone silence bit mutes headphone amplifier
// - Polarity bit 0: high sense means plugged; 1: low means plugged
// - Indication invert flips pin report only, not speaker auto-mute
// - Loudspeaker code 0..31 spans -34.5dB to 12dB, 1.5dB steps
// - Loudspeaker silence bit mutes loudspeaker amplifier
// - Jack-silence bit mutes speaker while headphone detected
// - Class D off bit disables amplifier, enables external one
// - Input divider 4..31, 1 bypass, 2 halves, 3 acts as 4
// - Modulus bits 4:2 from input divider reg, 1:0 from output reg
// - Feedback integer 4..127, values 0..3 act as 4
// - Oscillator range bit tunes for up to 100MHz
// - Output divider 4..15, smaller values act as 4
// - Dither code 00,01,10,11 gives magnitude 32,16,48,0
// - Feedback ratio is integer plus modulus over 32
// - Output frequency is input times ratio over input times output divide
// - Clock source bit selects synthesizer input clock
// - Serial write is 16 bits MSB first: address byte then data byte
`timescale 1ns/1ns

module audio_codec_gain_pll_regs #(
    parameter int unsigned NUM_REGS = codec_cfg_pkg::NUM_REGS
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire codec_cfg_pkg::serial_pins_t serial_i,
    input wire logic jack_sense_input_i,
    input wire logic speaker_mode_i,
    output codec_cfg_pkg::voice_ctrl_t voice_o,
    output codec_cfg_pkg::mic_ctrl_t mic_o,
    output codec_cfg_pkg::headphone_ctrl_t headphone_o,
    output codec_cfg_pkg::loudspeaker_ctrl_t loudspeaker_o,
    output codec_cfg_pkg::synth_ctrl_t synth_o
);
    import codec_cfg_pkg::*;

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [1:0] sclk_sync;
        logic sclk_prev;
        logic [1:0] enable_n_sync;
        logic [1:0] data_sync;
        logic [1:0] jack_sync;
        logic [WORD_BITS-1:0] shift;
        logic [4:0] bit_count;
        logic [NUM_REGS-1:0][7:0] regs;
        voice_ctrl_t voice;
        mic_ctrl_t mic;
        headphone_ctrl_t headphone;
        loudspeaker_ctrl_t loudspeaker;
        synth_ctrl_t synth;
    } state_t;

    state_t state_reg;
    state_t state_next;

    assign voice_o = state_reg.voice;
    assign mic_o = state_reg.mic;
    assign headphone_o = state_reg.headphone;
    assign loudspeaker_o = state_reg.loudspeaker;
    assign synth_o = state_reg.synth;

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb begin
        logic sclk_rise;
        logic [WORD_BITS-1:0] word;
        logic [7:0] addr;
        logic [7:0] r_voice;
        logic [7:0] r_mic;
        logic [7:0] r_hp;
        logic [7:0] r_ls;
        logic [7:0] r_in;
        logic [7:0] r_fb;
        logic [7:0] r_out;
        logic [7:0] r_clk;
        logic jack_present;
        logic ls_jack_muted;
        logic [4:0] in_div;
        logic [6:0] fb_int;
        logic [3:0] out_div;
        logic [4:0] modulus;
        sclk_rise = 1'b0;
        word = '0;
        addr = '0;
        r_voice = '0;
        r_mic = '0;
        r_hp = '0;
        r_ls = '0;
        r_in = '0;
        r_fb = '0;
        r_out = '0;
        r_clk = '0;
        jack_present = 1'b0;
        ls_jack_muted = 1'b0;
        in_div = '0;
        fb_int = '0;
        out_div = '0;
        modulus = '0;
        state_next = state_reg;

        // Pins are asynchronous to ref_clk_i; stage 0 feeds stage 1 only
        state_next.sclk_sync = {state_reg.sclk_sync[0], serial_i.sclk};
        state_next.enable_n_sync = {state_reg.enable_n_sync[0], serial_i.enable_n};
        state_next.data_sync = {state_reg.data_sync[0], serial_i.data};
        state_next.jack_sync = {state_reg.jack_sync[0], jack_sense_input_i};
        state_next.sclk_prev = state_reg.sclk_sync[1];
        sclk_rise = state_reg.sclk_sync[1] & ~state_reg.sclk_prev;

        // Serial write port; bits beyond the sixteenth are dropped until
        // the enable is released, so a long frame cannot smear two words.
        if (state_reg.enable_n_sync[1]) begin
            state_next.bit_count = '0;
        end else if (sclk_rise && state_reg.bit_count < 5'(WORD_BITS)) begin
            word = {state_reg.shift[WORD_BITS-2:0], state_reg.data_sync[1]};
            state_next.shift = word;
            state_next.bit_count = state_reg.bit_count + 5'h01;
            if (state_reg.bit_count == 5'(WORD_BITS - 1)) begin
                addr = word[15:8];
                // Unmapped addresses are silently ignored
                if (addr >= ADDR_VOICEBAND_CODEC_SETUP && addr <= 8'(NUM_REGS)) begin
                    state_next.regs[addr - 8'h01] = word[7:0];
                end
            end
        end

        r_voice = state_reg.regs[ADDR_VOICEBAND_CODEC_SETUP - 8'h01];
        r_mic = state_reg.regs[ADDR_MICROPHONE_PREAMP_SETUP - 8'h01];
        r_hp = state_reg.regs[ADDR_HEADPHONE_LEVEL_SETUP - 8'h01];
        r_ls = state_reg.regs[ADDR_LOUDSPEAKER_LEVEL_SETUP - 8'h01];
        r_in = state_reg.regs[ADDR_SYNTH_INPUT_DIVIDER - 8'h01];
        r_fb = state_reg.regs[ADDR_SYNTH_FEEDBACK_DIVIDER - 8'h01];
        r_out = state_reg.regs[ADDR_SYNTH_OUTPUT_DIVIDER - 8'h01];
        r_clk = state_reg.regs[ADDR_CLOCK_SOURCE_SELECT - 8'h01];

        // ---------------------------------------------------------------
        // Jack sense and loudspeaker auto-mute
        // ---------------------------------------------------------------
        jack_present = state_reg.jack_sync[1] ^ r_hp[POLARITY_BIT];
        ls_jack_muted = r_ls[LS_JACK_BIT] & jack_present;

        // ---------------------------------------------------------------
        // Voiceband codec
        // ---------------------------------------------------------------
        // Codes above the top step saturate to the 0dB step
        if (r_voice[3:0] > SIDETONE_TOP_CODE) begin
            state_next.voice.sidetone_level = SIDETONE_TOP_CODE;
        end else begin
            state_next.voice.sidetone_level = r_voice[3:0];
        end
        // Sidetone stays when the speaker is already silenced by the jack
        state_next.voice.sidetone_on = (r_voice[3:0] != 4'h0)
            & ~(r_voice[AUTO_SIDE_BIT] & speaker_mode_i & ~ls_jack_muted);
        state_next.voice.voice_adc_noise_shaping_off = r_voice[VADC_SHAPING_BIT];
        state_next.voice.voice_dac_noise_shaping_off = r_voice[VDAC_SHAPING_BIT];

        // ---------------------------------------------------------------
        // Microphone
        // ---------------------------------------------------------------
        state_next.mic.mic_level = r_mic[3:0];
        state_next.mic.mic_silence = r_mic[MIC_SILENCE_BIT];
        state_next.mic.voice_highpass_bypass = r_mic[HIGHPASS_BIT];

        // ---------------------------------------------------------------
        // Headphone
        // ---------------------------------------------------------------
        state_next.headphone.headphone_level = r_hp[4:0];
        state_next.headphone.headphone_silence = r_hp[HP_SILENCE_BIT];
        state_next.headphone.jack_present_indication =
            jack_present ^ r_hp[INDICATION_BIT];

        // ---------------------------------------------------------------
        // Loudspeaker
        // ---------------------------------------------------------------
        state_next.loudspeaker.loudspeaker_level = r_ls[4:0];
        // Inversion of the indication never reaches this term
        state_next.loudspeaker.loudspeaker_silence =
            r_ls[LS_SILENCE_BIT] | ls_jack_muted;
        state_next.loudspeaker.class_d_off = r_ls[CLASS_D_BIT];
        state_next.loudspeaker.external_amp_enable = r_ls[CLASS_D_BIT];

        // ---------------------------------------------------------------
        // Synthesizer dividers
        // ---------------------------------------------------------------
        // A zero input divider is taken as bypass as well
        if (r_in[4:0] <= IN_DIV_BYPASS) begin
            in_div = IN_DIV_BYPASS;
        end else if (r_in[4:0] == IN_DIV_FIXUP_CODE) begin
            in_div = IN_DIV_MIN;
        end else begin
            in_div = r_in[4:0];
        end
        if (r_fb[6:0] < FB_DIV_MIN) begin
            fb_int = FB_DIV_MIN;
        end else begin
            fb_int = r_fb[6:0];
        end
        if (r_out[3:0] < OUT_DIV_MIN) begin
            out_div = OUT_DIV_MIN;
        end else begin
            out_div = r_out[3:0];
        end
        modulus = {r_in[MOD_HIGH_LSB +: 3], r_out[MOD_LOW_LSB +: 2]};

        state_next.synth.input_divide = in_div;
        state_next.synth.feedback_integer = fb_int;
        state_next.synth.modulus = modulus;
        // Ratio in 1/32 units; zero modulus leaves a pure integer ratio
        state_next.synth.feedback_ratio_x32 = {fb_int, modulus};
        state_next.synth.output_divide = out_div;
        // Fout = Fin * ratio_x32 / (32 * total_divide)
        // Widen both factors first: a 5-bit product would wrap above 31
        state_next.synth.total_divide = 9'(in_div) * 9'(out_div);
        state_next.synth.oscillator_high_range = r_fb[OSC_RANGE_BIT];
        case (r_out[DITHER_LSB +: 2])
            2'b00: state_next.synth.dither_magnitude = DITHER_MAG_00;
            2'b01: state_next.synth.dither_magnitude = DITHER_MAG_01;
            2'b10: state_next.synth.dither_magnitude = DITHER_MAG_10;
            default: state_next.synth.dither_magnitude = DITHER_MAG_11;
        endcase
        state_next.synth.clock_source_select = r_clk[CLK_SOURCE_BIT];
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

endmodule : audio_codec_gain_pll_regs

// File: codec_cfg_asserts.sv
`timescale 1ns/1ns
module codec_cfg_asserts
    import codec_cfg_pkg::*;
#(
    parameter int unsigned NUM_REGS = 8
) (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire codec_cfg_pkg::serial_pins_t serial_i,
    input wire logic jack_sense_input_i,
    input wire logic speaker_mode_i,
    input wire codec_cfg_pkg::voice_ctrl_t voice_o,
    input wire codec_cfg_pkg::mic_ctrl_t mic_o,
    input wire codec_cfg_pkg::headphone_ctrl_t headphone_o,
    input wire codec_cfg_pkg::loudspeaker_ctrl_t loudspeaker_o,
    input wire codec_cfg_pkg::synth_ctrl_t synth_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    // ----
    // Decoded outputs are zero only at the first edge after reset
    // ----
    logic [1:0] up_cnt_reg;
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            up_cnt_reg <= 2'h0;
        end else if (up_cnt_reg != 2'h3) begin
            up_cnt_reg <= up_cnt_reg + 2'h1;
        end
    end

    AST_RESET_CLEAR: assert property ($fell(rst_i) |->
        {voice_o, mic_o, headphone_o, loudspeaker_o, synth_o} == '0)
        else $error("outputs not cleared by reset");
    AST_SIDE_TOP: assert property (voice_o.sidetone_level <= SIDETONE_TOP_CODE)
        else $error("sidetone code above top");
    AST_SIDE_MUTE: assert property (voice_o.sidetone_level == 4'h0 |-> !voice_o.sidetone_on)
        else $error("sidetone passes at code zero");
    AST_EXT_AMP: assert property (loudspeaker_o.external_amp_enable == loudspeaker_o.class_d_off)
        else $error("external enable differs from class D off");
    AST_IN_DIV: assert property (up_cnt_reg[1] |-> !(synth_o.input_divide inside {5'h00, 5'h03}))
        else $error("input divide illegal");
    AST_FB_MIN: assert property (up_cnt_reg[1] |-> synth_o.feedback_integer >= FB_DIV_MIN)
        else $error("feedback integer below minimum");
    AST_OUT_MIN: assert property (up_cnt_reg[1] |-> synth_o.output_divide >= OUT_DIV_MIN)
        else $error("output divide below minimum");
    AST_RATIO: assert property (synth_o.feedback_ratio_x32 ==
        {synth_o.feedback_integer, synth_o.modulus})
        else $error("feedback ratio mismatch");
    AST_TOTAL: assert property (synth_o.total_divide ==
        9'(synth_o.input_divide) * 9'(synth_o.output_divide))
        else $error("total divide mismatch");
    AST_DITHER: assert property (synth_o.dither_magnitude inside {6'h20, 6'h10, 6'h30, 6'h00})
        else $error("dither magnitude illegal");
    AST_JACK_HOLD: assert property (($stable(jack_sense_input_i) && serial_i.enable_n)[*5] |->
        $stable({headphone_o.jack_present_indication, loudspeaker_o.loudspeaker_silence}))
        else $error("jack outputs moved without cause");
endmodule : codec_cfg_asserts

bind audio_codec_gain_pll_regs codec_cfg_asserts #(.NUM_REGS(NUM_REGS)) i_chk (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_i(serial_i),
    .jack_sense_input_i(jack_sense_input_i), .speaker_mode_i(speaker_mode_i),
    .voice_o(voice_o), .mic_o(mic_o), .headphone_o(headphone_o),
    .loudspeaker_o(loudspeaker_o), .synth_o(synth_o));

// File: serial_host_model.sv
`timescale 1ns/1ns
module serial_host_model
    import codec_cfg_pkg::*;
(
    input wire logic ref_clk_i,
    output codec_cfg_pkg::serial_pins_t serial_o
);
    initial serial_o = '{sclk: 1'b0, enable_n: 1'b1, data: 1'b0};

    // Sends n bits MSB first; n other than 16 is a deliberate framing fault
    task automatic send(input logic [15:0] word, input int n);
        @(negedge ref_clk_i);
        serial_o.enable_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            serial_o.data = word[15 - (i % 16)];
            repeat (4) @(negedge ref_clk_i);
            serial_o.sclk = 1'b1;
            repeat (4) @(negedge ref_clk_i);
            serial_o.sclk = 1'b0;
        end
        repeat (4) @(negedge ref_clk_i);
        serial_o.enable_n = 1'b1;
        // Deselected line must not keep looking valid
        serial_o.data = ~serial_o.data;
        repeat (6) @(negedge ref_clk_i);
    endtask : send
endmodule : serial_host_model

// File: tb.sv
`timescale 1ns/1ns
module tb;
    import codec_cfg_pkg::*;
    logic ref_clk_i;
    logic rst_i;
    logic sense;
    logic spk;
    serial_pins_t serial;
    voice_ctrl_t voice;
    mic_ctrl_t mic;
    headphone_ctrl_t hp;
    loudspeaker_ctrl_t ls;
    synth_ctrl_t synth;
    logic [7:0] r [1:8];
    logic [15:0] seed;
    int miscompares;
    int cmp_count;

    initial ref_clk_i = 1'b0;
    always #4 ref_clk_i = ~ref_clk_i;

    serial_host_model u_host (.ref_clk_i(ref_clk_i), .serial_o(serial));
    audio_codec_gain_pll_regs i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .serial_i(serial),
        .jack_sense_input_i(sense), .speaker_mode_i(spk), .voice_o(voice), .mic_o(mic),
        .headphone_o(hp), .loudspeaker_o(ls), .synth_o(synth));

    // ----
    // Checking and expectation
    // ----
    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic check_all();
        logic pr;
        logic [3:0] st;
        logic [4:0] m;
        logic [6:0] n;
        logic [3:0] p;
        logic [5:0] dm;
        logic [49:0] ex;
        pr = sense ^ r[3][6];
        st = (r[1][3:0] > SIDETONE_TOP_CODE) ? SIDETONE_TOP_CODE : r[1][3:0];
        m = (r[5][4:0] < 5'h02) ? 5'h01 : (r[5][4:0] == 5'h03) ? 5'h04 : r[5][4:0];
        n = (r[6][6:0] < 7'h04) ? 7'h04 : r[6][6:0];
        p = (r[7][3:0] < 4'h4) ? 4'h4 : r[7][3:0];
        dm = 6'({6'h00, 6'h30, 6'h10, 6'h20} >> (6 * r[7][7:6]));
        ex = {m, n, r[5][7:5], r[7][5:4], n, r[5][7:5], r[7][5:4], p, 9'(m) * 9'(p), r[6][7], dm,
            r[8][0]};
        check("voice", 64'(voice), 64'({st, st != 4'h0 && !(r[1][4] && spk && !(r[4][6] && pr)),
            r[1][6], r[1][7]}));
        check("mic", 64'(mic), 64'({r[2][3:0], r[2][4], r[2][7]}));
        check("hp", 64'(hp), 64'({r[3][4:0], r[3][5], pr ^ r[3][7]}));
        check("ls", 64'(ls), 64'({r[4][4:0], r[4][5] | (r[4][6] & pr), r[4][7], r[4][7]}));
        check("synth", 64'(synth), 64'(ex));
    endtask : check_all

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input int n);
        logic [7:0] keep;
        keep = (a == 8'h01) ? 8'hdf : (a == 8'h02) ? 8'h9f : (a == 8'h08) ? 8'h7f : 8'hff;
        u_host.send({a, d & keep}, n);
        if (n >= 16 && a >= 8'h01 && a <= 8'h08) r[a] = d & keep;
        check_all();
    endtask : wr

    task automatic do_reset(input int n);
        rst_i = 1'b1;
        repeat (n) @(negedge ref_clk_i);
        rst_i = 1'b0;
        for (int i = 1; i <= 8; i++) r[i] = 8'h00;
        repeat (4) @(negedge ref_clk_i);
        check_all();
    endtask : do_reset

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize

    // ----
    // Scenarios
    // ----
    initial begin
        rst_i = 1'b1;
        sense = 1'b0;
        spk = 1'b0;
        seed = 16'h5c12;
        miscompares = 0;
        cmp_count = 0;
        do_reset(8);
        for (int c = 0; c < 16; c++) wr(8'h01, 8'(c), 16);
        spk = 1'b1;
        wr(8'h01, 8'h15, 16);
        wr(8'h04, 8'h40, 16);
        sense = 1'b1;
        repeat (6) @(negedge ref_clk_i);
        check_all();
        wr(8'h03, 8'h40, 16);
        wr(8'h03, 8'hc0, 16);
        wr(8'h04, 8'hbf, 16);
        for (int k = 0; k < 8; k++) begin
            wr(8'h05, {k[2:0], 5'(k == 7 ? 31 : k)}, 16);
            wr(8'h06, {k[0], 7'(k == 7 ? 127 : k)}, 16);
            wr(8'h07, {k[1:0], k[1:0], 4'(k == 7 ? 15 : k)}, 16);
        end
        wr(8'h08, 8'h01, 16);
        wr(8'h00, 8'hff, 16);
        wr(8'h09, 8'hff, 16);
        wr(8'h02, 8'h9f, 15);
        wr(8'h02, 8'h93, 20);
        for (int i = 0; i < 30; i++) begin
            seed = lfsr_next(seed);
            sense = seed[12];
            spk = seed[13];
            wr({4'h0, seed[11:8]}, seed[7:0], 16);
        end
        do_reset(2);
        summarize();
    end

    initial begin
        repeat (40000) @(posedge ref_clk_i);
        miscompares++;
        summarize();
    end
endmodule : tb
